// [rtl/hsavg_top.sv]
`timescale 1ns/1ns
module hsavg_top
   import hsavg_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   input wire logic REF_CLK,
   input wire logic RST,
   // sample source, same clock
   input wire logic SAMPLE_VALID,
   output logic SAMPLE_READY,
   input wire logic [SAMPLE_W-1:0] SAMPLE_DATA,
   // conversion control
   input wire logic SINGLE_SET,
   input wire logic STOP_CLEAR,
   output logic SINGLE_PENDING,
   output logic STOP,
   output logic MEAS_ACTIVE,
   output logic MEAS_STROBE,
   // filter configuration
   input wire logic CFG_WRITE,
   input wire logic [2:0] BURST_SIZE_LOG2,
   input wire logic [3:0] AVERAGE_COUNT_LOG2,
   input wire logic RECURSIVE_FILTER_SELECT,
   output logic [2:0] BURST_SIZE_LOG2_Q,
   output logic [3:0] AVERAGE_COUNT_LOG2_Q,
   output logic RECURSIVE_FILTER_SELECT_Q,
   output logic [SAMPLE_W-1:0] FIELD_RESULT,
   output logic RESULT_FRESH,
   // storage indirect read
   input wire logic STORE_ADDR_WRITE,
   input wire logic [7:0] STORE_ADDR,
   input wire logic STORE_READ_SET,
   output logic STORE_READ_EN,
   output logic STORE_BUSY,
   output logic [7:0] STORE_DATA,
   output logic [7:0] STORE_ARRAY_ADDR,
   input wire logic [7:0] STORE_ARRAY_DATA,
   // restore of live configuration
   input wire logic WAKE,
   input wire logic RETAIN_SWITCH,
   output logic RESTORE_BUSY,
   output logic CFG_LOAD_STROBE,
   output logic [7:0] CFG_LOAD_INDEX,
   output logic [7:0] CFG_LOAD_DATA,
   // test coil
   input wire logic [1:0] TEST_COIL_DRIVE,
   output logic COIL_POS_EN,
   output logic COIL_NEG_EN
);
   localparam int ACC_W = SAMPLE_W + 12;
   // timer must hold the first-measurement count, which exceeds ten bits
   localparam int TW = $clog2(FIRST_MEAS_CYC + 1);
   hsavg_state_e state_q;
   logic [TW-1:0] tmr_q;
   logic [12:0] cnt_q, need_q;
   logic first_q, mode_q;
   logic [ACC_W-1:0] acc_q;
   logic [SAMPLE_W-1:0] win [4096];
   logic [11:0] wptr_q;
   logic [12:0] fill_q;
   logic [SAMPLE_W-1:0] avg_q, iir_q, res_q;
   logic iir_init_q;
   logic f_valid, f_ready, f_in_ready;
   logic [SAMPLE_W-1:0] f_data;
   logic [SAMPLE_W-1:0] old_s;
   logic [3:0] bw_q;
   logic [2:0] bs_q;
   // ***********************************
   // helpers
   // ***********************************
   function automatic logic [12:0] pow2(input logic [3:0] e);
      pow2 = 13'h1 << e;
   endfunction
   function automatic logic [3:0] clip_bw(input logic [3:0] v);
      clip_bw = (v > BW_MAX) ? BW_MAX : v;
   endfunction
   // one recursion step, old*(2^bw-1)/2^bw + new/2^bw, rounded down
   function automatic logic [SAMPLE_W-1:0] iir_step(
      input logic [SAMPLE_W-1:0] old_v,
      input logic [SAMPLE_W-1:0] new_v,
      input logic [3:0] e);
      logic [ACC_W-1:0] sum_v;
      sum_v = ACC_W'(old_v) * ACC_W'(pow2(e) - 13'h1) + ACC_W'(new_v);
      iir_step = SAMPLE_W'(sum_v >> e);
   endfunction
   // ***********************************
   // sample buffer
   // ***********************************
   // samples queue here while the measurement timer runs
   hsavg_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(REF_CLK), .rst(RST), .in_valid(SAMPLE_VALID),
      .in_ready(f_in_ready), .in_data(SAMPLE_DATA), .out_valid(f_valid),
      .out_ready(f_ready), .out_data(f_data));
   assign SAMPLE_READY = f_in_ready;
   // a sample is consumed only once its measurement time has elapsed
   assign f_ready = (state_q == HS_MEAS) && (tmr_q == '0);
   // ***********************************
   // configuration registers
   // ***********************************
   // restore writes the filter byte; bus writes win otherwise
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         bw_q <= '0;
         bs_q <= '0;
         mode_q <= 1'b0;
      end else if (CFG_LOAD_STROBE && CFG_LOAD_INDEX == CFG_FILTER_BYTE) begin
         bs_q <= CFG_LOAD_DATA[7:5];
         bw_q <= clip_bw(CFG_LOAD_DATA[4:1]);
         mode_q <= CFG_LOAD_DATA[0];
      end else if (CFG_WRITE) begin
         bs_q <= BURST_SIZE_LOG2;
         bw_q <= clip_bw(AVERAGE_COUNT_LOG2);
         mode_q <= RECURSIVE_FILTER_SELECT;
      end
   end
   assign BURST_SIZE_LOG2_Q = bs_q;
   assign AVERAGE_COUNT_LOG2_Q = bw_q;
   assign RECURSIVE_FILTER_SELECT_Q = mode_q;
   // ***********************************
   // conversion sequencer
   // ***********************************
   // one measurement per sample, timed before the sample is taken
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state_q <= HS_IDLE;
         tmr_q <= '0;
         cnt_q <= '0;
         need_q <= 13'h1;
         first_q <= 1'b0;
      end else begin
         case (state_q)
            HS_IDLE: begin
               if (SINGLE_PENDING && !STOP) begin
                  // fir burst length from bandwidth, iir from burst size
                  need_q <= mode_q ? pow2({1'b0, bs_q}) : pow2(bw_q);
                  cnt_q <= '0;
                  first_q <= 1'b1;
                  tmr_q <= TW'(FIRST_MEAS_CYC - 1);
                  state_q <= HS_MEAS;
               end
            end
            HS_MEAS: begin
               if (tmr_q != '0) begin
                  tmr_q <= tmr_q - 1'b1;
               end else if (f_valid) begin
                  state_q <= HS_ACC;
               end
            end
            HS_ACC: begin
               first_q <= 1'b0;
               if (cnt_q + 13'h1 == need_q) begin
                  state_q <= HS_AVG;
               end else begin
                  cnt_q <= cnt_q + 13'h1;
                  // this cycle and the pop edge count toward the period
                  tmr_q <= TW'(NEXT_MEAS_CYC - 2);
                  state_q <= HS_MEAS;
               end
            end
            HS_AVG: begin
               state_q <= HS_DONE;
            end
            HS_DONE: begin
               state_q <= HS_IDLE;
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end
   assign MEAS_ACTIVE = (state_q != HS_IDLE);
   // single conversion clears as it starts; stop set on completion
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         SINGLE_PENDING <= 1'b0;
         STOP <= 1'b1;
      end else begin
         if (state_q == HS_IDLE && SINGLE_PENDING && !STOP) begin
            SINGLE_PENDING <= 1'b0;
         end else if (SINGLE_SET) begin
            SINGLE_PENDING <= 1'b1;
         end
         if (state_q == HS_DONE) begin
            STOP <= 1'b1;
         end else if (STOP_CLEAR) begin
            STOP <= 1'b0;
         end
      end
   end
   // ***********************************
   // averaging datapath
   // ***********************************
   assign old_s = win[wptr_q];
   // window memory, no reset: stale slots are masked by the fill count
   always_ff @(posedge REF_CLK) begin
      if (state_q == HS_MEAS && f_ready && f_valid) begin
         win[wptr_q] <= f_data;
      end
   end
   // fir keeps a running sum over the last 2^bw samples
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         acc_q <= '0;
         wptr_q <= '0;
         fill_q <= '0;
      end else if (CFG_WRITE || CFG_LOAD_STROBE) begin
         acc_q <= '0;
         wptr_q <= '0;
         fill_q <= '0;
      end else if (state_q == HS_MEAS && f_ready && f_valid) begin
         if (mode_q) begin
            acc_q <= (first_q ? '0 : acc_q) + ACC_W'(f_data);
         end else begin
            // drop the sample leaving the window once it is full
            acc_q <= acc_q + ACC_W'(f_data) - ((fill_q == pow2(bw_q)) ?
               ACC_W'(old_s) : '0);
            wptr_q <= (wptr_q + 12'h1) & 12'(pow2(bw_q) - 13'h1);
            if (fill_q != pow2(bw_q)) begin
               fill_q <= fill_q + 13'h1;
            end
         end
      end
   end
   // burst average, then fir result or iir recursion
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         avg_q <= '0;
         iir_q <= '0;
         iir_init_q <= 1'b0;
         res_q <= '0;
         MEAS_STROBE <= 1'b0;
      end else begin
         MEAS_STROBE <= 1'b0;
         if (state_q == HS_AVG) begin
            avg_q <= mode_q ? SAMPLE_W'(acc_q >> bs_q)
               : SAMPLE_W'(acc_q >> bw_q);
         end
         if (state_q == HS_DONE) begin
            MEAS_STROBE <= 1'b1;
            if (mode_q) begin
               // first burst seeds the recursion to avoid a long ramp
               iir_q <= iir_init_q ? iir_step(iir_q, avg_q, bw_q)
                  : avg_q;
               iir_init_q <= 1'b1;
               res_q <= iir_init_q ? iir_step(iir_q, avg_q, bw_q)
                  : avg_q;
            end else begin
               res_q <= avg_q;
            end
         end
         if (CFG_WRITE) begin
            iir_init_q <= 1'b0;
         end
      end
   end
   assign FIELD_RESULT = res_q;
   // fresh flag: set with each result, dropped once the next burst measures
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RESULT_FRESH <= 1'b0;
      end else begin
         RESULT_FRESH <= (state_q == HS_DONE) ? 1'b1 :
            (state_q == HS_MEAS ? 1'b0 : RESULT_FRESH);
      end
   end
   // ***********************************
   // storage read and restore
   // ***********************************
   logic [7:0] addr_q, ridx_q;
   logic [1:0] rtmr_q;
   logic rst_seen_q;
   // indirect read stalls while a restore owns the storage port
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         addr_q <= '0;
         STORE_READ_EN <= 1'b0;
         STORE_DATA <= '0;
         rtmr_q <= '0;
      end else begin
         if (STORE_ADDR_WRITE) begin
            addr_q <= STORE_ADDR;
         end
         if (STORE_READ_EN && !RESTORE_BUSY) begin
            if (rtmr_q == 2'(STORE_READ_CYC - 1)) begin
               // any byte incl. part, variant, serial reads back
               STORE_DATA <= STORE_ARRAY_DATA;
               STORE_READ_EN <= 1'b0;
               rtmr_q <= '0;
            end else begin
               rtmr_q <= rtmr_q + 2'h1;
            end
         end else if (STORE_READ_SET) begin
            STORE_READ_EN <= 1'b1;
         end
      end
   end
   assign STORE_BUSY = STORE_READ_EN || RESTORE_BUSY;
   // restore walks the config bytes, one per two cycles
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RESTORE_BUSY <= 1'b0;
         rst_seen_q <= 1'b0;
         ridx_q <= CFG_FIRST;
         CFG_LOAD_STROBE <= 1'b0;
         CFG_LOAD_INDEX <= '0;
         CFG_LOAD_DATA <= '0;
      end else begin
         CFG_LOAD_STROBE <= 1'b0;
         rst_seen_q <= 1'b1;
         if (!RESTORE_BUSY && (!rst_seen_q || WAKE)) begin
            RESTORE_BUSY <= 1'b1;
            ridx_q <= (rst_seen_q && RETAIN_SWITCH) ?
               CFG_RETAIN_LAST + 8'h1 : CFG_FIRST;
         end else if (RESTORE_BUSY && !CFG_LOAD_STROBE) begin
            CFG_LOAD_STROBE <= 1'b1;
            CFG_LOAD_INDEX <= ridx_q;
            CFG_LOAD_DATA <= STORE_ARRAY_DATA;
         end else if (RESTORE_BUSY) begin
            if (ridx_q == CFG_LAST) begin
               RESTORE_BUSY <= 1'b0;
            end else begin
               ridx_q <= ridx_q + 8'h1;
            end
         end
      end
   end
   assign STORE_ARRAY_ADDR = RESTORE_BUSY ? ridx_q : addr_q;
   // ***********************************
   // test coil
   // ***********************************
   // registered enables, so a code change never glitches the drivers
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         COIL_POS_EN <= 1'b0;
         COIL_NEG_EN <= 1'b0;
      end else begin
         // codes 00 and 11 both leave the coil off
         COIL_POS_EN <= (TEST_COIL_DRIVE == COIL_POS);
         COIL_NEG_EN <= (TEST_COIL_DRIVE == COIL_NEG);
      end
   end
endmodule

// [rtl/hsavg_pkg.sv]
package hsavg_pkg;
   // ***********************************
   // timing
   // ***********************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int FIRST_MEAS_NS = 11000;
   localparam int NEXT_MEAS_NS = 8800;
   localparam int FIRST_MEAS_CYC = (FIRST_MEAS_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int NEXT_MEAS_CYC = (NEXT_MEAS_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   // ***********************************
   // field limits and storage map
   // ***********************************
   localparam logic [3:0] BW_MAX = 4'hc;
   localparam logic [2:0] BURST_MAX = 3'h7;
   localparam logic [7:0] CFG_FIRST = 8'h04;
   localparam logic [7:0] CFG_LAST = 8'h0f;
   localparam logic [7:0] CFG_RETAIN_LAST = 8'h05;
   localparam logic [7:0] CFG_FILTER_BYTE = 8'h0c;
   localparam logic [7:0] PART_BYTE = 8'h14;
   localparam logic [7:0] VARIANT_BYTE = 8'h15;
   localparam logic [7:0] SERIAL_FIRST = 8'h18;
   localparam logic [7:0] SERIAL_LAST = 8'h1b;
   localparam int STORE_READ_CYC = 2;
   localparam int FIFO_DEPTH = 16;
   // ***********************************
   // coil drive codes
   // ***********************************
   localparam logic [1:0] COIL_POS = 2'h1;
   localparam logic [1:0] COIL_NEG = 2'h2;
   typedef enum logic [2:0] {
      HS_IDLE = 3'h0, HS_MEAS = 3'h1, HS_ACC = 3'h2, HS_AVG = 3'h3,
      HS_DONE = 3'h4
   } hsavg_state_e;
endpackage

// [rtl/hsavg_fifo.sv]
`timescale 1ns/1ns
module hsavg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   logic push, pop;
   // honest full and empty from the fill count
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end
   // pointers and count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [bench/hsavg_chk.sv]
`timescale 1ns/1ns
module hsavg_chk
   import hsavg_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [1:0] TEST_COIL_DRIVE,
   input wire logic COIL_POS_EN,
   input wire logic COIL_NEG_EN,
   input wire logic MEAS_STROBE,
   input wire logic MEAS_ACTIVE,
   input wire logic STOP,
   input wire logic SINGLE_PENDING,
   input wire logic [SAMPLE_W-1:0] FIELD_RESULT,
   input wire logic STORE_READ_SET,
   input wire logic STORE_READ_EN,
   input wire logic STORE_BUSY,
   input wire logic CFG_LOAD_STROBE,
   input wire logic [7:0] CFG_LOAD_INDEX,
   input wire logic [3:0] AVERAGE_COUNT_LOG2_Q
);
   // *****************************
   // sequences and properties
   // *****************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // a read taken while nothing else owns the storage; one set during a restore is also taken and stalls
   sequence s_read_take;
      STORE_READ_SET && !STORE_BUSY;
   endsequence
   sequence s_conv_take;
      SINGLE_PENDING && !STOP && !MEAS_ACTIVE;
   endsequence
   coil_pos_a: assert property (1 |=> COIL_POS_EN ==
      ($past(TEST_COIL_DRIVE) == COIL_POS)) else $error("coil pos wrong");
   coil_neg_a: assert property (1 |=> COIL_NEG_EN ==
      ($past(TEST_COIL_DRIVE) == COIL_NEG)) else $error("coil neg wrong");
   strobe_pulse_a: assert property (MEAS_STROBE |=> !MEAS_STROBE)
      else $error("strobe longer than one cycle");
   strobe_stop_a: assert property (MEAS_STROBE |-> ##[0:1] STOP)
      else $error("stop not set at burst end");
   result_hold_a: assert property ($changed(FIELD_RESULT) |->
      MEAS_STROBE) else $error("result moved without strobe");
   read_take_a: assert property (s_read_take |=> STORE_READ_EN
      ##[1:3] !STORE_READ_EN) else $error("read enable not self cleared");
   read_busy_a: assert property (STORE_READ_EN |-> STORE_BUSY)
      else $error("busy low during read");
   conv_take_a: assert property (s_conv_take |=> MEAS_ACTIVE
      && !SINGLE_PENDING) else $error("single request not taken");
   bw_limit_a: assert property (AVERAGE_COUNT_LOG2_Q <= BW_MAX)
      else $error("bandwidth above limit");
   load_range_a: assert property (CFG_LOAD_STROBE |->
      CFG_LOAD_INDEX >= CFG_FIRST && CFG_LOAD_INDEX <= CFG_LAST)
      else $error("restore index out of range");
endmodule
bind hsavg_top hsavg_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.REF_CLK(REF_CLK),
   .RST(RST), .TEST_COIL_DRIVE(TEST_COIL_DRIVE), .COIL_POS_EN(COIL_POS_EN),
   .COIL_NEG_EN(COIL_NEG_EN), .MEAS_STROBE(MEAS_STROBE),
   .MEAS_ACTIVE(MEAS_ACTIVE), .STOP(STOP), .SINGLE_PENDING(SINGLE_PENDING),
   .FIELD_RESULT(FIELD_RESULT), .STORE_READ_SET(STORE_READ_SET),
   .STORE_READ_EN(STORE_READ_EN), .STORE_BUSY(STORE_BUSY),
   .CFG_LOAD_STROBE(CFG_LOAD_STROBE), .CFG_LOAD_INDEX(CFG_LOAD_INDEX),
   .AVERAGE_COUNT_LOG2_Q(AVERAGE_COUNT_LOG2_Q));

// [bench/hsavg_store_model.sv]
`timescale 1ns/1ns
module hsavg_store_model #(
   parameter logic [7:0] KEY = 8'h5a
) (
   input wire logic [7:0] addr,
   output logic [7:0] data
);
   // every byte answers in the same cycle; part, variant and serial
   // bytes come out of this pattern, so their values are arbitrary
   assign data = addr ^ KEY;
endmodule

// [bench/tb_hall_sample_averaging_otp_read.sv]
`timescale 1ns/1ns
module tb_hall_sample_averaging_otp_read;
   import hsavg_pkg::*;
   localparam logic [7:0] KEY = 8'h5a;
   localparam logic [7:0] RD_LIST [7] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h1a,
      8'h1b, 8'h04};
   localparam logic [1:0] COIL_LIST [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
   logic ref_clk, rst, s_valid, s_ready, single_set, stop_clear, pend, stop;
   logic active, strobe, cfg_wr, iir_sel, iir_q, fresh, a_wr, rd_set, rd_en;
   logic busy, wake, retain, r_busy, ld_stb, pos_en, neg_en;
   logic [15:0] s_data, result;
   logic [2:0] bs, bs_q;
   logic [3:0] bw, bw_q;
   logic [7:0] a_in, s_dat, arr_a, arr_d, ld_idx, ld_dat, first_idx;
   logic [1:0] coil;
   int n_errors, samples_checked, n_loads;
   hsavg_top uut (.REF_CLK(ref_clk), .RST(rst), .SAMPLE_VALID(s_valid),
      .SAMPLE_READY(s_ready), .SAMPLE_DATA(s_data), .SINGLE_SET(single_set),
      .STOP_CLEAR(stop_clear), .SINGLE_PENDING(pend), .STOP(stop),
      .MEAS_ACTIVE(active), .MEAS_STROBE(strobe), .CFG_WRITE(cfg_wr),
      .BURST_SIZE_LOG2(bs), .AVERAGE_COUNT_LOG2(bw),
      .RECURSIVE_FILTER_SELECT(iir_sel), .BURST_SIZE_LOG2_Q(bs_q),
      .AVERAGE_COUNT_LOG2_Q(bw_q), .RECURSIVE_FILTER_SELECT_Q(iir_q),
      .FIELD_RESULT(result), .RESULT_FRESH(fresh), .STORE_ADDR_WRITE(a_wr),
      .STORE_ADDR(a_in), .STORE_READ_SET(rd_set), .STORE_READ_EN(rd_en),
      .STORE_BUSY(busy), .STORE_DATA(s_dat), .STORE_ARRAY_ADDR(arr_a),
      .STORE_ARRAY_DATA(arr_d), .WAKE(wake), .RETAIN_SWITCH(retain),
      .RESTORE_BUSY(r_busy), .CFG_LOAD_STROBE(ld_stb),
      .CFG_LOAD_INDEX(ld_idx), .CFG_LOAD_DATA(ld_dat),
      .TEST_COIL_DRIVE(coil), .COIL_POS_EN(pos_en), .COIL_NEG_EN(neg_en));
   hsavg_store_model #(.KEY(KEY)) u_store (.addr(arr_a), .data(arr_d));
   // *****************************
   // clock, monitor, watchdog
   // *****************************
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   // counts restore loads and remembers where each restore began
   always @(posedge ref_clk) begin
      if (ld_stb === 1'b1) begin
         if (n_loads == 0) first_idx <= ld_idx;
         n_loads <= n_loads + 1;
      end
   end
   // longest run is about 20k cycles, so 40k cycles leaves ample margin
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
   // *****************************
   // tasks
   // *****************************
   task automatic tick();
      @(negedge ref_clk);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // a short pause first, as the restore may not have started yet
   task automatic wait_restore();
      tick();
      tick();
      for (int i = 0; i < 300 && r_busy !== 1'b0; i++) tick();
      check(r_busy, 0);
   endtask
   task automatic read_store(input logic [7:0] addr);
      a_in = addr;
      a_wr = 1;
      tick();
      a_wr = 0;
      rd_set = 1;
      tick();
      rd_set = 0;
      check(busy, 1);
      for (int i = 0; i < 20 && rd_en !== 1'b0; i++) tick();
      check(rd_en, 0);
      check(s_dat, addr ^ KEY);
   endtask
   task automatic cfg(input logic [2:0] b, input logic [3:0] w,
      input logic i);
      bs = b;
      bw = w;
      iir_sel = i;
      cfg_wr = 1;
      tick();
      cfg_wr = 0;
      tick();
   endtask
   task automatic push(input logic [15:0] d);
      for (int i = 0; i < 5000 && s_ready !== 1'b1; i++) tick();
      s_data = d;
      s_valid = 1;
      tick();
      s_valid = 0;
      tick();
   endtask
   task automatic conv(input logic [15:0] exp, input int n);
      int c, t;
      t = FIRST_MEAS_CYC + NEXT_MEAS_CYC * (n - 1) + 4;
      stop_clear = 1;
      tick();
      stop_clear = 0;
      single_set = 1;
      tick();
      single_set = 0;
      c = 1;
      while (strobe !== 1'b1 && c < 20000) begin
         tick();
         c++;
      end
      check(result, exp);
      check(c >= t && c <= t + 6, 1);
      tick();
      check({stop, pend, fresh}, 3'h5);
   endtask
   // *****************************
   // main sequence
   // *****************************
   initial begin
      {s_valid, single_set, stop_clear, cfg_wr, iir_sel, a_wr} = '0;
      {rd_set, wake, retain, bs, bw, a_in, coil, s_data} = '0;
      n_errors = 0;
      samples_checked = 0;
      n_loads = 0;
      rst = 1;
      repeat (2) @(posedge ref_clk);
      tick();
      rst = 0;
      wait_restore();
      check(stop, 1);
      check(n_loads, 12);
      check(first_idx, CFG_FIRST);
      check({bs_q, bw_q, iir_q}, CFG_FILTER_BYTE ^ KEY);
      foreach (RD_LIST[k]) begin
         read_store(RD_LIST[k]);
      end
      cfg(3'h7, 4'hf, 1'b0);
      check({bs_q, bw_q}, {BURST_MAX, BW_MAX});
      // fir over 16 samples also fills the buffer to refusal
      cfg(3'h0, 4'h4, 1'b0);
      for (int i = 0; i < 16; i++) push(16'(i * 32));
      check(s_ready, 0);
      conv(16'd240, 16);
      check(s_ready, 1);
      // iir with bursts of two: first burst seeds, then halves
      cfg(3'h1, 4'h1, 1'b1);
      check(iir_q, 1);
      push(16'd100);
      push(16'd200);
      conv(16'd150, 2);
      push(16'd300);
      push(16'd500);
      conv(16'd275, 2);
      // wake with and without retained switch bytes
      for (int r = 1; r >= 0; r--) begin
         n_loads = 0;
         retain = r[0];
         wake = 1;
         tick();
         wake = 0;
         wait_restore();
         check(n_loads, r ? 10 : 12);
         check(first_idx, r ? 8'h06 : CFG_FIRST);
         check({bs_q, bw_q, iir_q}, CFG_FILTER_BYTE ^ KEY);
      end
      // every coil code, off between the two directions
      foreach (COIL_LIST[k]) begin
         coil = COIL_LIST[k];
         tick();
         tick();
         check({pos_en, neg_en}, {coil == 2'h1, coil == 2'h2});
      end
      summarize();
   end
endmodule
